//--- shared/acb_pkg.sv
/*
 * Package for the gain-control and test-mode configuration bank: register offsets,
 * field positions, reset values and the carrier structs.
 * Assumes a byte-wide configuration port with even byte offsets.
 */
// Summary of operation
// - Loop gain register holds a 7-bit fraction in bits 6:0; bit 7 unused.
// - Under override, manual gain bit 7 drives the receive RF gain output.
// - Under override, manual gain bits 6:0 feed the gain DAC instead of loop IF.
// - With polarity clear, RF bit one removes the 30dB pad, zero inserts it.
// - Continuous update lets updates run in freeze and lock only with run-on-freeze.
// - Polarity bit zero leaves RF gain output alone; one inverts it.
// - On lock, one extra final update unless the extra-update disable bit is set.
// - Lock verification runs when its bit is zero, bypassed when one.
// - Run-on-freeze keeps estimating after acquisition without changing RF or IF gain.
// - Override enable gives the manual gain register both RF and IF gain control.
// - Random I/Q bit with PN enabled feeds pseudo-random 6-bit I and Q to the loop.
// - Test-math mode makes gain adjust accumulate always and log table output mean power.
// - RF threshold holds 7-bit threshold in 6:0; bit 7 disables it.
// - Mid step is twice its field; low step is bits 3:0; applied above saturation counts.
// - Negative lock window is a 5-bit magnitude negated by the logic.
// - Second carrier-sense scale is 6-bit, used only with the dot product source.
// - Transmit power DAC gets signed bits 7:1; bit 0 unused.
// - In DAC test mode seven, bit 7 picks Barker output or low-rate samples.
// - Scrambler-disable forces all scrambler taps to zero.
// - Each PN enable initialises only after a zero write precedes a one write.
// - Converter bypass takes sample bits 5:2 from the test bus, low bits zero.
// - Loopback bypasses converters, serial input becomes lock, external signals ignored.
// - Mid and low saturation count thresholds are 4-bit counts triggering the steps.
package acb_pkg;
	localparam logic [7:0] ADDR_LOOP_GAIN = 8'h30;
	localparam logic [7:0] ADDR_MANUAL_GAIN = 8'h32;
	localparam logic [7:0] ADDR_TEST_CONTROLS = 8'h34;
	localparam logic [7:0] ADDR_RF_THRESHOLD = 8'h36;
	localparam logic [7:0] ADDR_SAT_ATTEN = 8'h38;
	localparam logic [7:0] ADDR_NEG_WINDOW = 8'h3A;
	localparam logic [7:0] ADDR_CS_SCALE = 8'h3C;
	localparam logic [7:0] ADDR_TX_POWER = 8'h3E;
	localparam logic [7:0] ADDR_TEST_FIRST = 8'h40;
	localparam logic [7:0] ADDR_TEST_SECOND = 8'h42;
	localparam logic [7:0] ADDR_TEST_BUS_SEL = 8'h44;
	localparam logic [7:0] ADDR_MF_THRESHOLD = 8'h46;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// Test controls bits.
	localparam int TC_CONTINUOUS = 7;
	localparam int TC_POLARITY = 6;
	localparam int TC_EXTRA_OFF = 5;
	localparam int TC_VERIFY_OFF = 4;
	localparam int TC_RUN_FREEZE = 3;
	localparam int TC_OVERRIDE = 2;
	localparam int TC_RANDOM_IQ = 1;
	localparam int TC_TEST_MATH = 0;
	// Test modes first bits.
	localparam int TF_DAC_SEL7 = 7;
	localparam int TF_HIGH_RATE = 6;
	localparam int TF_TX44 = 5;
	localparam int TF_BUS_INPUTS = 4;
	localparam int TF_NO_SPREAD = 3;
	localparam int TF_SCRAMBLE_OFF = 2;
	localparam int TF_PN44 = 1;
	localparam int TF_PN22 = 0;
	// Test modes second bits.
	localparam int TS_DC_OFF = 5;
	localparam int TS_ADC_BYPASS = 4;
	localparam int TS_TIME_ADJ_OFF = 3;
	localparam int TS_LOOPBACK = 2;
	localparam int TS_PN_BUS_LOW = 1;
	localparam int TS_PN_BUS_HIGH = 0;
	localparam int MSB = 7;
	localparam int SAMPLE_W = 6;
	localparam logic [6:0] PN_SEED = 7'h7F;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} acb_bus_req_type;

	typedef struct packed {
		logic [SAMPLE_W-1:0] i;
		logic [SAMPLE_W-1:0] q;
	} acb_iq_type;

	typedef struct packed {
		logic continuous_update;
		logic extra_update;
		logic lock_verify;
		logic run_on_freeze;
		logic random_iq;
		logic test_math;
		logic [6:0] loop_gain;
		logic [6:0] threshold;
		logic threshold_disable;
		logic [4:0] mid_step;
		logic [3:0] low_step;
		logic [5:0] neg_window;
		logic [5:0] cs2_scale;
	} acb_agc_cfg_type;

	typedef struct packed {
		logic dac_sel7_low_rate;
		logic force_high_rate;
		logic tx44_enable;
		logic bus_inputs;
		logic spread_disable;
		logic scrambler_taps_off;
		logic dc_offset_disable;
		logic time_adjust_disable;
		logic pn_bus_low;
		logic pn_bus_high;
		logic [7:0] test_bus_address;
		logic [7:0] mf_threshold;
	} acb_test_cfg_type;
endpackage : acb_pkg

//--- logic/acb_config_bank.sv
/*
 * Gain-control and test-mode configuration bank with its output steering: manual
 * gain override, RF polarity, PN test data, converter bypass and loopback muxing.
 * Assumes the host strobes are synchronous to i_clk, one cycle long and never together.
 */
`timescale 1ns/10ps
`default_nettype none
module acb_config_bank
	import acb_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Configuration port.
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Gain loop results and front-end samples.
	input wire logic i_loop_rf_gain,
	input wire logic [6:0] i_loop_if_gain,
	input wire logic [5:0] i_adc_i,
	input wire logic [5:0] i_adc_q,
	input wire logic [7:0] i_test_bus_input,
	input wire logic i_serial_input_pin,
	input wire logic i_ext_lock,
	input wire logic i_acquired,
	input wire logic i_gain_loop_locked,
	// Gain outputs.
	output logic o_receive_rf_gain_output,
	output logic [6:0] o_if_gain_dac,
	output logic o_gain_update_enable,
	output logic o_estimate_update_enable,
	output logic o_extra_update_pulse,
	output logic [6:0] o_tx_power_dac,
	// Data path steering.
	output acb_iq_type o_agc_iq,
	output logic o_acq_lock,
	output logic o_dac_low_rate_select,
	output logic o_pn44_init,
	output logic o_pn22_init,
	output logic o_pn44_run,
	output logic o_pn22_run,
	output logic o_loopback,
	output logic [6:0] o_neg_window,
	output acb_agc_cfg_type o_agc_cfg,
	output acb_test_cfg_type o_test_cfg
);
	typedef struct packed {
		logic [7:0] loop_gain;
		logic [7:0] manual_gain;
		logic [7:0] test_controls;
		logic [7:0] rf_threshold;
		logic [7:0] sat_atten;
		logic [7:0] neg_window;
		logic [7:0] cs_scale;
		logic [7:0] tx_power;
		logic [7:0] test_first;
		logic [7:0] test_second;
		logic [7:0] test_bus_sel;
		logic [7:0] mf_threshold;
		logic [7:0] rdata;
		logic [6:0] pn_state;
		logic pn44_armed;
		logic pn22_armed;
		logic pn44_init;
		logic pn22_init;
		logic locked_d;
		logic extra_pulse;
	} acb_state_type;

	acb_state_type state;
	acb_state_type next_state;
	acb_bus_req_type req;

	// Seven-bit maximal-length shift for the test pattern source.
	function automatic logic [6:0] pn_step(input logic [6:0] s);
		pn_step = {s[5:0], s[6] ^ s[5]};
	endfunction : pn_step

	always_comb begin
		req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	end

	always_comb begin
		next_state = state;
		next_state.pn44_init = 1'b0;
		next_state.pn22_init = 1'b0;
		if (req.wr) begin
			case (req.addr)
				ADDR_LOOP_GAIN: next_state.loop_gain = req.wdata;
				ADDR_MANUAL_GAIN: next_state.manual_gain = req.wdata;
				ADDR_TEST_CONTROLS: next_state.test_controls = req.wdata;
				ADDR_RF_THRESHOLD: next_state.rf_threshold = req.wdata;
				ADDR_SAT_ATTEN: next_state.sat_atten = req.wdata;
				ADDR_NEG_WINDOW: next_state.neg_window = req.wdata;
				ADDR_CS_SCALE: next_state.cs_scale = req.wdata;
				ADDR_TX_POWER: next_state.tx_power = req.wdata;
				ADDR_TEST_FIRST: begin
					next_state.test_first = req.wdata;
					// A zero write arms, a following one write starts the generator.
					if (!req.wdata[TF_PN44]) begin
						next_state.pn44_armed = 1'b1;
					end else if (state.pn44_armed) begin
						next_state.pn44_armed = 1'b0;
						next_state.pn44_init = 1'b1;
					end
					if (!req.wdata[TF_PN22]) begin
						next_state.pn22_armed = 1'b1;
					end else if (state.pn22_armed) begin
						next_state.pn22_armed = 1'b0;
						next_state.pn22_init = 1'b1;
					end
				end
				ADDR_TEST_SECOND: next_state.test_second = req.wdata;
				ADDR_TEST_BUS_SEL: next_state.test_bus_sel = req.wdata;
				ADDR_MF_THRESHOLD: next_state.mf_threshold = req.wdata;
				default: begin
				end
			endcase
		end
		next_state.rdata = UNMAPPED_READ;
		if (req.rd) begin
			case (req.addr)
				ADDR_LOOP_GAIN: next_state.rdata = state.loop_gain;
				ADDR_MANUAL_GAIN: next_state.rdata = state.manual_gain;
				ADDR_TEST_CONTROLS: next_state.rdata = state.test_controls;
				ADDR_RF_THRESHOLD: next_state.rdata = state.rf_threshold;
				ADDR_SAT_ATTEN: next_state.rdata = state.sat_atten;
				ADDR_NEG_WINDOW: next_state.rdata = state.neg_window;
				ADDR_CS_SCALE: next_state.rdata = state.cs_scale;
				ADDR_TX_POWER: next_state.rdata = state.tx_power;
				ADDR_TEST_FIRST: next_state.rdata = state.test_first;
				ADDR_TEST_SECOND: next_state.rdata = state.test_second;
				ADDR_TEST_BUS_SEL: next_state.rdata = state.test_bus_sel;
				ADDR_MF_THRESHOLD: next_state.rdata = state.mf_threshold;
				default: next_state.rdata = UNMAPPED_READ;
			endcase
		end
		// The pattern restarts on init so both ends of a loop test see one sequence.
		if (state.pn44_init || state.pn22_init) begin
			next_state.pn_state = PN_SEED;
		end else if (state.test_first[TF_PN44] || state.test_first[TF_PN22]) begin
			next_state.pn_state = pn_step(state.pn_state);
		end
		next_state.locked_d = i_gain_loop_locked;
		next_state.extra_pulse = i_gain_loop_locked && !state.locked_d
			&& !state.test_controls[TC_EXTRA_OFF];
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	logic override;
	logic pn_on;
	logic frozen;
	logic rf_raw;
	always_comb begin
		override = state.test_controls[TC_OVERRIDE];
		pn_on = state.test_first[TF_PN44] || state.test_first[TF_PN22];
		frozen = i_acquired || i_gain_loop_locked;
		// RF control chooses manual bit or loop, then polarity applies to either.
		rf_raw = override ? state.manual_gain[MSB] : i_loop_rf_gain;
		o_receive_rf_gain_output = rf_raw ^ state.test_controls[TC_POLARITY];
		o_if_gain_dac = override ? state.manual_gain[6:0] : i_loop_if_gain;
		// With override clear, gains move while acquiring, or afterwards only with both freeze bits set.
		o_gain_update_enable = !override && (!frozen
			|| (state.test_controls[TC_CONTINUOUS]
			&& state.test_controls[TC_RUN_FREEZE]));
		o_estimate_update_enable = !frozen || state.test_controls[TC_RUN_FREEZE];
		o_extra_update_pulse = state.extra_pulse;
		o_tx_power_dac = state.tx_power[7:1];
		o_loopback = state.test_second[TS_LOOPBACK];
		o_acq_lock = o_loopback ? i_serial_input_pin : i_ext_lock;
		if (o_loopback) begin
			o_agc_iq = '0;
		end else if (state.test_second[TS_ADC_BYPASS]) begin
			o_agc_iq.i = {i_test_bus_input[3:0], 2'b00};
			o_agc_iq.q = {i_test_bus_input[7:4], 2'b00};
		end else if (state.test_controls[TC_RANDOM_IQ] && pn_on) begin
			o_agc_iq.i = state.pn_state[5:0];
			o_agc_iq.q = {state.pn_state[0], state.pn_state[6:2]};
		end else begin
			o_agc_iq.i = i_adc_i;
			o_agc_iq.q = i_adc_q;
		end
		o_dac_low_rate_select = state.test_first[TF_DAC_SEL7];
		o_pn44_init = state.pn44_init;
		o_pn22_init = state.pn22_init;
		o_pn44_run = state.test_first[TF_PN44];
		o_pn22_run = state.test_first[TF_PN22];
		o_neg_window = 7'(-$signed({2'b00, state.neg_window[4:0]}));
		o_agc_cfg.continuous_update = state.test_controls[TC_CONTINUOUS]
			&& state.test_controls[TC_RUN_FREEZE];
		o_agc_cfg.extra_update = !state.test_controls[TC_EXTRA_OFF];
		o_agc_cfg.lock_verify = !state.test_controls[TC_VERIFY_OFF];
		o_agc_cfg.run_on_freeze = state.test_controls[TC_RUN_FREEZE];
		o_agc_cfg.random_iq = state.test_controls[TC_RANDOM_IQ] && pn_on;
		o_agc_cfg.test_math = state.test_controls[TC_TEST_MATH];
		o_agc_cfg.loop_gain = state.loop_gain[6:0];
		o_agc_cfg.threshold = state.rf_threshold[6:0];
		o_agc_cfg.threshold_disable = state.rf_threshold[MSB];
		o_agc_cfg.mid_step = {state.sat_atten[7:4], 1'b0};
		o_agc_cfg.low_step = state.sat_atten[3:0];
		o_agc_cfg.neg_window = {1'b0, state.neg_window[4:0]};
		o_agc_cfg.cs2_scale = state.cs_scale[5:0];
		o_test_cfg.dac_sel7_low_rate = state.test_first[TF_DAC_SEL7];
		o_test_cfg.force_high_rate = state.test_first[TF_HIGH_RATE];
		o_test_cfg.tx44_enable = state.test_first[TF_TX44];
		o_test_cfg.bus_inputs = state.test_first[TF_BUS_INPUTS];
		o_test_cfg.spread_disable = state.test_first[TF_NO_SPREAD];
		o_test_cfg.scrambler_taps_off = state.test_first[TF_SCRAMBLE_OFF];
		o_test_cfg.dc_offset_disable = state.test_second[TS_DC_OFF];
		o_test_cfg.time_adjust_disable = state.test_second[TS_TIME_ADJ_OFF];
		o_test_cfg.pn_bus_low = state.test_second[TS_PN_BUS_LOW];
		o_test_cfg.pn_bus_high = state.test_second[TS_PN_BUS_HIGH];
		o_test_cfg.test_bus_address = state.test_bus_sel;
		o_test_cfg.mf_threshold = state.mf_threshold;
		o_rdata = state.rdata;
	end
endmodule : acb_config_bank
`default_nettype wire

//--- dv/acb_config_bank_chk.sv
/*
 * Port assertions for the configuration bank.
 * Assumes one clock domain and a bind onto every acb_config_bank.
 */
`timescale 1ns/10ps
`default_nettype none
module acb_chk
	import acb_pkg::*;
(
	// Clock, reset and bus.
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// Gain and path signals.
	input wire logic [6:0] i_loop_if_gain,
	input wire logic i_serial_input_pin,
	input wire logic i_ext_lock,
	input wire logic i_acquired,
	input wire logic i_gain_loop_locked,
	input wire logic [6:0] o_if_gain_dac,
	input wire logic o_gain_update_enable,
	input wire logic o_estimate_update_enable,
	input wire logic [6:0] o_tx_power_dac,
	input wire logic o_acq_lock,
	input wire logic o_pn44_init,
	input wire logic o_pn44_run,
	input wire logic o_loopback,
	input wire logic [6:0] o_neg_window,
	input wire acb_agc_cfg_type o_agc_cfg
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	a_tx_power: assert property (
		i_wr && i_addr == ADDR_TX_POWER |=> o_tx_power_dac == $past(i_wdata[7:1]))
		else $error("tx power field wrong");
	a_neg_window: assert property (
		i_wr && i_addr == ADDR_NEG_WINDOW |=> o_neg_window == 7'h00 - {2'b00, $past(i_wdata[4:0])})
		else $error("negative window wrong");
	a_loop_gain: assert property (
		i_wr && i_addr == ADDR_LOOP_GAIN |=> o_agc_cfg.loop_gain == $past(i_wdata[6:0]))
		else $error("loop gain wrong");
	a_sat_steps: assert property (
		i_wr && i_addr == ADDR_SAT_ATTEN |=> o_agc_cfg.mid_step == {$past(i_wdata[7:4]), 1'b0}
		&& o_agc_cfg.low_step == $past(i_wdata[3:0]))
		else $error("saturation steps wrong");
	a_reg_readback: assert property (
		i_wr && i_addr == ADDR_LOOP_GAIN ##1 !i_wr ##1 i_rd && i_addr == ADDR_LOOP_GAIN
		|=> o_rdata == $past(i_wdata, 3))
		else $error("readback wrong");
	a_lock_source: assert property (
		o_acq_lock == (o_loopback ? i_serial_input_pin : i_ext_lock))
		else $error("lock source wrong");
	a_loop_passthru: assert property (
		o_gain_update_enable |-> o_if_gain_dac == i_loop_if_gain)
		else $error("loop gain not passed");
	a_freeze_hold: assert property (
		o_agc_cfg.run_on_freeze && !o_agc_cfg.continuous_update && (i_acquired || i_gain_loop_locked)
		|-> !o_gain_update_enable && o_estimate_update_enable)
		else $error("run on freeze wrong");
	a_cont_needs_run: assert property (
		!o_agc_cfg.run_on_freeze && (i_acquired || i_gain_loop_locked) |-> !o_gain_update_enable)
		else $error("update during freeze");
	a_pn_pulse: assert property (
		o_pn44_init |-> o_pn44_run ##1 !o_pn44_init)
		else $error("pn init pulse wrong");
endmodule : acb_chk
bind acb_config_bank acb_chk acb_chk_i (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .i_loop_if_gain, .i_serial_input_pin, .i_ext_lock, .i_acquired, .i_gain_loop_locked,
	.o_if_gain_dac, .o_gain_update_enable, .o_estimate_update_enable, .o_tx_power_dac, .o_acq_lock,
	.o_pn44_init, .o_pn44_run, .o_loopback, .o_neg_window, .o_agc_cfg);
`default_nettype wire

//--- dv/acb_host_model.sv
/*
 * Host controller model driving the configuration port.
 * Assumes the bank answers reads in the cycle after the strobe.
 */
`timescale 1ns/10ps
`default_nettype none
module acb_host_model
	import acb_pkg::*;
(
	// Clock.
	input wire logic i_clk,
	// Requests and answer.
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	input wire logic [7:0] i_rdata
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// The short wait after each task's last edge lets the bank's outputs settle before anyone looks.
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		#1;
	endtask : write
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask : read
	// A generator only starts cleanly when its enable is cleared first.
	task automatic pn_start(input logic [7:0] v);
		write(ADDR_TEST_FIRST, 8'h00);
		write(ADDR_TEST_FIRST, v);
	endtask : pn_start
endmodule : acb_host_model
`default_nettype wire

//--- dv/acb_config_bank_tb.sv
/*
 * Self-checking testbench for the configuration bank.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/10ps
`default_nettype none
module acb_config_bank_tb
	import acb_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [7:0] i_addr, i_wdata, o_rdata, d;
	logic i_wr, i_rd, o_receive_rf_gain_output, o_gain_update_enable, o_estimate_update_enable;
	logic o_extra_update_pulse, o_acq_lock, o_dac_low_rate_select, o_pn44_init, o_pn22_init;
	logic o_pn44_run, o_pn22_run, o_loopback, s;
	logic i_loop_rf_gain = 1'b0;
	logic [6:0] i_loop_if_gain = 7'h11;
	logic [5:0] i_adc_i = 6'h2B;
	logic [5:0] i_adc_q = 6'h15;
	logic [7:0] i_test_bus_input = 8'hA5;
	logic i_serial_input_pin = 1'b1;
	logic i_ext_lock = 1'b0;
	logic i_acquired = 1'b0;
	logic i_gain_loop_locked = 1'b0;
	logic [6:0] o_if_gain_dac, o_tx_power_dac, o_neg_window;
	acb_iq_type o_agc_iq;
	acb_agc_cfg_type o_agc_cfg;
	acb_test_cfg_type o_test_cfg;
	int err_count = 0;
	int checks = 0;
	always #12.5 i_clk = ~i_clk;
	acb_config_bank acb_config_bank_i (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_loop_rf_gain, .i_loop_if_gain, .i_adc_i, .i_adc_q, .i_test_bus_input,
		.i_serial_input_pin, .i_ext_lock, .i_acquired, .i_gain_loop_locked,
		.o_receive_rf_gain_output, .o_if_gain_dac, .o_gain_update_enable,
		.o_estimate_update_enable, .o_extra_update_pulse, .o_tx_power_dac, .o_agc_iq,
		.o_acq_lock, .o_dac_low_rate_select, .o_pn44_init, .o_pn22_init, .o_pn44_run,
		.o_pn22_run, .o_loopback, .o_neg_window, .o_agc_cfg, .o_test_cfg);
	acb_host_model hm (.i_clk, .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd),
		.i_rdata(o_rdata));
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic print_verdict();
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	// Pulses are one cycle wide, so every cycle of the window is sampled.
	task automatic pulse_seen(input int sel, output logic seen);
		seen = 1'b0;
		repeat (3) begin
			seen = seen | ((sel == 0 ? o_extra_update_pulse
				: (sel == 1 ? o_pn44_init : o_pn22_init)) === 1'b1);
			@(posedge i_clk);
			#1;
		end
	endtask : pulse_seen
	task automatic t_regs(input logic [7:0] x);
		for (int k = 0; k < 12; k++) begin
			if (x != 8'h00) hm.write(8'h30 + 8'(2 * k), x ^ 8'(k));
		end
		for (int k = 0; k < 12; k++) begin
			hm.read(8'h30 + 8'(2 * k), d);
			chk("register", x == 8'h00 ? 8'h00 : x ^ 8'(k), d);
		end
		hm.write(8'h48, 8'hFF);
		hm.read(8'h48, d);
		chk("unmapped", 8'h00, d);
	endtask : t_regs
	task automatic t_gain();
		@(posedge i_clk);
		i_loop_rf_gain <= 1'b1;
		hm.write(ADDR_MANUAL_GAIN, 8'h25);
		for (int k = 0; k < 4; k++) begin
			hm.write(ADDR_TEST_CONTROLS, {1'b0, k[1], 3'b000, k[0], 2'b00});
			chk("rf gain", {7'h00, k[1] ^ ~k[0]}, {7'h00, o_receive_rf_gain_output});
			chk("if gain", k[0] ? 8'h25 : 8'h11, {1'b0, o_if_gain_dac});
		end
	endtask : t_gain
	task automatic t_fields();
		hm.write(ADDR_TX_POWER, 8'h81);
		chk("tx power", 8'h40, {1'b0, o_tx_power_dac});
		hm.write(ADDR_NEG_WINDOW, 8'hEF);
		chk("neg window", 8'h71, {1'b0, o_neg_window});
		hm.write(ADDR_SAT_ATTEN, 8'hF9);
		chk("mid step", 8'h1E, {3'b000, o_agc_cfg.mid_step});
		chk("low step", 8'h09, {4'h0, o_agc_cfg.low_step});
		hm.write(ADDR_LOOP_GAIN, 8'hFF);
		hm.read(ADDR_LOOP_GAIN, d);
		chk("loop gain", 8'hFF, d);
	endtask : t_fields
	task automatic t_cfg();
		hm.write(ADDR_TEST_CONTROLS, 8'h13);
		chk("lock verify", 8'h00, {7'h00, o_agc_cfg.lock_verify});
		chk("test math", 8'h01, {7'h00, o_agc_cfg.test_math});
		chk("random iq", 8'h01, {7'h00, o_agc_cfg.random_iq});
		hm.write(ADDR_TEST_FIRST, 8'h84);
		chk("random off", 8'h00, {7'h00, o_agc_cfg.random_iq});
		chk("iq adc", 8'h2B, {2'b00, o_agc_iq.i});
		chk("dac select", 8'h01, {7'h00, o_dac_low_rate_select});
		chk("scrambler", 8'h01, {7'h00, o_test_cfg.scrambler_taps_off});
		hm.write(ADDR_RF_THRESHOLD, 8'hC0);
		chk("threshold", 8'h40, {1'b0, o_agc_cfg.threshold});
		chk("thresh off", 8'h01, {7'h00, o_agc_cfg.threshold_disable});
		hm.write(ADDR_CS_SCALE, 8'hFF);
		chk("cs2 scale", 8'h3F, {2'b00, o_agc_cfg.cs2_scale});
		hm.write(ADDR_TEST_CONTROLS, 8'h00);
		chk("lock verify", 8'h01, {7'h00, o_agc_cfg.lock_verify});
	endtask : t_cfg
	task automatic t_freeze();
		logic [7:0] tcs [4] = '{8'h08, 8'h88, 8'h80, 8'h8C};
		@(posedge i_clk);
		i_acquired <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			hm.write(ADDR_TEST_CONTROLS, tcs[k]);
			chk("gain update", {7'h00, k == 1}, {7'h00, o_gain_update_enable});
			chk("estimate", {7'h00, k != 2}, {7'h00, o_estimate_update_enable});
		end
		@(posedge i_clk);
		i_acquired <= 1'b0;
	endtask : t_freeze
	task automatic t_extra(input logic [7:0] tc, input logic exp);
		hm.write(ADDR_TEST_CONTROLS, tc);
		@(posedge i_clk);
		i_gain_loop_locked <= 1'b1;
		#1;
		pulse_seen(0, s);
		chk("extra update", {7'h00, exp}, {7'h00, s});
		@(posedge i_clk);
		i_gain_loop_locked <= 1'b0;
	endtask : t_extra
	task automatic t_paths();
		hm.write(ADDR_TEST_SECOND, 8'h10);
		chk("bypass i", 8'h14, {2'b00, o_agc_iq.i});
		chk("bypass q", 8'h28, {2'b00, o_agc_iq.q});
		hm.write(ADDR_TEST_SECOND, 8'h04);
		chk("loop lock", 8'h01, {7'h00, o_acq_lock});
		chk("loop iq", 8'h00, {2'b00, o_agc_iq.i});
		hm.write(ADDR_TEST_SECOND, 8'h00);
		chk("normal lock", 8'h00, {7'h00, o_acq_lock});
		chk("adc i", 8'h2B, {2'b00, o_agc_iq.i});
	endtask : t_paths
	initial begin
		repeat (5000) @(posedge i_clk);
		err_count++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		t_regs(8'h00);
		t_regs(8'hC3);
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		t_regs(8'h00);
		hm.write(ADDR_TEST_FIRST, 8'h02);
		pulse_seen(1, s);
		chk("pn unarmed", 8'h00, {7'h00, s});
		hm.pn_start(8'h02);
		pulse_seen(1, s);
		chk("pn armed", 8'h01, {7'h00, s});
		hm.pn_start(8'h01);
		pulse_seen(2, s);
		chk("pn22 armed", 8'h01, {7'h00, s});
		t_gain();
		t_fields();
		t_cfg();
		t_freeze();
		t_extra(8'h00, 1'b1);
		t_extra(8'h20, 1'b0);
		t_paths();
		print_verdict();
	end
endmodule : acb_config_bank_tb
`default_nettype wire
